// [pmc_power_ctrl.sv]
// CPU power mode control: idle and stop modes driven by the power control register.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_power_ctrl #(
  parameter int CLD_CYCLES = `PMC_CLD_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Special-function register bus from the core.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Instruction sequencing from the core.
  input wire logic instr_done,
  input wire logic next_instr_one_byte,
  // Wake and reset sources.
  input wire logic irq_pending,
  input wire logic watchdog_reset,
  input wire logic ext_reset_pin_n,
  input wire logic clock_loss_detector_en,
  // Clock gates and oscillator control.
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_run,
  // Mode and reset status.
  output logic idle_active,
  output logic stop_active,
  output logic reset_request,
  output logic [15:0] restart_vector
);
  import pmc_pkg::*;

  pmc_regs_t st;
  pmc_regs_t next_st;
  logic cld_timeout;
  logic wr_hit;
  logic rd_hit;
  logic any_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by reads and writes.
  function automatic logic pmc_hit(input logic [7:0] addr);
    pmc_hit = (addr == `PMC_POWER_CONTROL_ADDR);
  endfunction : pmc_hit

  assign wr_hit = sfr_wr && pmc_hit(sfr_addr);
  assign rd_hit = sfr_rd && pmc_hit(sfr_addr);

  ////////////////////////////////////////////////////////////////////////////
  // Clock-loss detector. It watches the oscillator enable, which only drops in
  // stop, so it is the one timer left alive there.
  pmc_clock_loss #(
    .CYCLES(CLD_CYCLES)
  ) u_clock_loss (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(clock_loss_detector_en),
    .sysclk_running(st.osc_run),
    .timeout(cld_timeout)
  );

  // Reset sources that can end a low-power mode. The watchdog is ignored in
  // stop because it has no clock there.
  always_comb begin
    any_reset = !st.ext_sync || cld_timeout;
    if (st.mode != PMC_STOP && st.mode != PMC_STOP_PEND) begin
      any_reset = any_reset || watchdog_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Everything here runs on mclk, which is never gated, so
  // an interrupt is seen even while the CPU clock is off.
  always_comb begin
    next_st = st;

    // External reset pin passes two flip-flops before use.
    next_st.ext_meta = ext_reset_pin_n;
    next_st.ext_sync = st.ext_meta;

    // Register reads: mode-select bits always return zero. Unmapped reads
    // return zero as well, so the core can OR read data from many sources.
    next_st.rdata = 8'h00;
    if (rd_hit) begin
      next_st.rdata[`PMC_GF_MSB:`PMC_GF_LSB] = st.general_flags;
    end

    // General flags are plain storage with no effect on the block.
    if (wr_hit) begin
      next_st.general_flags = sfr_wdata[`PMC_GF_MSB:`PMC_GF_LSB];
    end

    // Any reset request is held until the system reset lands and clears it.
    if (any_reset) begin
      next_st.reset_req = 1'b1;
    end

    case (st.mode)
      PMC_RUN: begin
        next_st.cpu_clk_en = 1'b1;
        next_st.periph_clk_en = 1'b1;
        next_st.osc_run = 1'b1;
        next_st.irq_in_write = 1'b0;
        // Stop wins when both select bits are written together, as the
        // deeper mode is the one software can only leave by a reset.
        if (wr_hit && sfr_wdata[`PMC_STOP_BIT]) begin
          next_st.mode = PMC_STOP_PEND;
        end else if (wr_hit && sfr_wdata[`PMC_IDLE_BIT]) begin
          next_st.mode = PMC_IDLE_PEND;
          next_st.irq_in_write = irq_pending;
        end
        // The write may be the last cycle of its own instruction.
        if (wr_hit && instr_done && (sfr_wdata[`PMC_STOP_BIT] || sfr_wdata[`PMC_IDLE_BIT])) begin
          if (sfr_wdata[`PMC_STOP_BIT]) begin
            next_st.mode = PMC_STOP;
            next_st.cpu_clk_en = 1'b0;
            next_st.periph_clk_en = 1'b0;
            next_st.osc_run = 1'b0;
            next_st.stop_active = 1'b1;
          end else begin
            next_st.mode = PMC_IDLE;
            next_st.cpu_clk_en = 1'b0;
            next_st.idle_active = 1'b1;
            if (irq_pending && next_instr_one_byte) begin
              next_st.wake_blocked = 1'b1;
            end
          end
        end
      end

      PMC_IDLE_PEND: begin
        // Still executing the idle-setting instruction; an interrupt seen now
        // is the hazard that a one-byte follower turns into a lost wake.
        if (irq_pending) begin
          next_st.irq_in_write = 1'b1;
        end
        if (instr_done) begin
          next_st.mode = PMC_IDLE;
          next_st.cpu_clk_en = 1'b0;
          next_st.idle_active = 1'b1;
          if ((st.irq_in_write || irq_pending) && next_instr_one_byte) begin
            next_st.wake_blocked = 1'b1;
          end
        end
      end

      PMC_IDLE: begin
        // Peripherals and oscillator keep running; only the CPU clock is
        // gated, which also freezes its registers and memory in place.
        next_st.periph_clk_en = 1'b1;
        next_st.osc_run = 1'b1;
        next_st.cpu_clk_en = 1'b0;
        // A blocked wake stays blocked until a reset clears the block; this
        // reproduces the known fault rather than hiding it.
        if (irq_pending && !st.wake_blocked && !any_reset) begin
          next_st.mode = PMC_RUN;
          next_st.cpu_clk_en = 1'b1;
          next_st.idle_active = 1'b0;
        end
      end

      PMC_STOP_PEND: begin
        if (instr_done) begin
          next_st.mode = PMC_STOP;
          next_st.cpu_clk_en = 1'b0;
          next_st.periph_clk_en = 1'b0;
          next_st.osc_run = 1'b0;
          next_st.stop_active = 1'b1;
        end
      end

      PMC_STOP: begin
        // Interrupts are not looked at: only a reset leaves this state, and
        // that reset returns the whole block to run through reset_n.
        next_st.cpu_clk_en = 1'b0;
        next_st.periph_clk_en = 1'b0;
        next_st.osc_run = 1'b0;
      end

      default: begin
        next_st.mode = PMC_RUN;
        next_st.cpu_clk_en = 1'b1;
        next_st.periph_clk_en = 1'b1;
        next_st.osc_run = 1'b1;
        next_st.idle_active = 1'b0;
        next_st.stop_active = 1'b0;
      end
    endcase

    // The restart address is fixed; the core loads it after every reset.
    next_st.restart_vector = `PMC_RESET_VECTOR;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register. Reset puts the core back in run with clocks on, so the
  // normal reset sequence can proceed from any mode.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st.mode <= PMC_RUN;
      st.general_flags <= 6'(`PMC_POWER_CONTROL_RESET >> `PMC_GF_LSB);
      st.rdata <= 8'h00;
      st.ext_meta <= 1'b1;
      st.ext_sync <= 1'b1;
      st.irq_in_write <= 1'b0;
      st.wake_blocked <= 1'b0;
      st.reset_req <= 1'b0;
      st.cpu_clk_en <= 1'b1;
      st.periph_clk_en <= 1'b1;
      st.osc_run <= 1'b1;
      st.idle_active <= 1'b0;
      st.stop_active <= 1'b0;
      st.restart_vector <= `PMC_RESET_VECTOR;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state register.
  assign sfr_rdata = st.rdata;
  assign cpu_clk_en = st.cpu_clk_en;
  assign periph_clk_en = st.periph_clk_en;
  assign osc_run = st.osc_run;
  assign idle_active = st.idle_active;
  assign stop_active = st.stop_active;
  assign reset_request = st.reset_req;
  assign restart_vector = st.restart_vector;

endmodule : pmc_power_ctrl
`default_nettype wire

// [pmc_defs.svh]
// Constants of the CPU power mode control: register map, fields, reset values, timing.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Power control register location and reset value.
`define PMC_POWER_CONTROL_ADDR 8'h87
`define PMC_POWER_CONTROL_RESET 8'h00

// Field positions inside the power control register.
`define PMC_IDLE_BIT 0
`define PMC_STOP_BIT 1
`define PMC_GF_LSB 2
`define PMC_GF_MSB 7

// Address at which execution restarts after any reset.
`define PMC_RESET_VECTOR 16'h0000

// System clock rate and clock-loss detector timeout.
`define PMC_CLK_MHZ 20
`define PMC_CLD_TIMEOUT_US 100
`define PMC_CLD_CYCLES (`PMC_CLD_TIMEOUT_US * `PMC_CLK_MHZ)
`define PMC_CLD_CNT_W 12

`endif

// [pmc_pkg.sv]
// Types shared by the CPU power mode control modules.
package pmc_pkg;

  // Power modes of the core.
  typedef enum logic [2:0] {
    PMC_RUN,
    PMC_IDLE_PEND,
    PMC_IDLE,
    PMC_STOP_PEND,
    PMC_STOP
  } pmc_mode_t;

  // Complete state of the mode controller.
  typedef struct packed {
    pmc_mode_t mode;
    logic [5:0] general_flags;
    logic [7:0] rdata;
    logic ext_meta;
    logic ext_sync;
    logic irq_in_write;
    logic wake_blocked;
    logic reset_req;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic idle_active;
    logic stop_active;
    logic [15:0] restart_vector;
  } pmc_regs_t;

  // Complete state of the clock-loss detector.
  typedef struct packed {
    logic [11:0] count;
    logic timeout;
  } pmc_cld_regs_t;

endpackage : pmc_pkg

// [pmc_clock_loss.sv]
// Clock-loss detector: one-shot timer that fires when the system clock stays stopped.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_clock_loss #(
  parameter int CYCLES = `PMC_CLD_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Control and observed clock.
  input wire logic enable,
  input wire logic sysclk_running,
  // Result.
  output logic timeout
);
  import pmc_pkg::*;

  pmc_cld_regs_t st;
  pmc_cld_regs_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // The count restarts whenever the system clock is seen running, so only an
  // unbroken stop longer than the timeout fires; the result holds until reset.
  always_comb begin
    next_st = st;
    if (!enable || sysclk_running) begin
      next_st.count = '0;
    end else if (st.count != CYCLES[11:0]) begin
      next_st.count = st.count + 12'h001;
    end
    if (enable && !sysclk_running && st.count == CYCLES[11:0] - 12'h001) begin
      next_st.timeout = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st.count <= 12'h000;
      st.timeout <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign timeout = st.timeout;

endmodule : pmc_clock_loss
`default_nettype wire

// [pmc_power_ctrl_chk.sv]
// Assertion checker for the CPU power mode control, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_power_ctrl_chk #(
  parameter int CLD_CYCLES = `PMC_CLD_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Sequencing and sources.
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic watchdog_reset,
  input wire logic ext_reset_pin_n,
  input wire logic clock_loss_detector_en,
  // Clock gates and status.
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic osc_run,
  input wire logic idle_active,
  input wire logic stop_active,
  input wire logic reset_request
);
  // Slack covers the detector stage and the request stage after it.
  localparam int CLD_MAX = CLD_CYCLES + 4;
  // Cycles spent in stop with the detector on and no reset asked for yet. A
  // counter is used because the detector timeout is far too long for a delay range.
  int stop_wait;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stop_wait <= 0;
    end else if (stop_active && clock_loss_detector_en && !reset_request) begin
      stop_wait <= stop_wait + 1;
    end else begin
      stop_wait <= 0;
    end
  end
  wire hit_wr = sfr_wr && sfr_addr == `PMC_POWER_CONTROL_ADDR;
  wire hit_rd = sfr_rd && sfr_addr == `PMC_POWER_CONTROL_ADDR;
  // Only a running core with no reset on the way may change mode.
  wire run = cpu_clk_en && !reset_request && !watchdog_reset;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////////
  property p_rd_zero; hit_rd |=> sfr_rdata[1:0] == 2'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("Mode bits read as one.");
  property p_flags;
    hit_wr ##1 !sfr_wr ##1 (hit_rd && !sfr_wr) |=>
      sfr_rdata == {$past(sfr_wdata[7:2], 3), 2'h0};
  endproperty
  a_flags: assert property (p_flags) else $error("Flags not kept.");
  property p_idle_clk; idle_active |-> !cpu_clk_en && periph_clk_en && osc_run; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("Idle clocks wrong.");
  property p_stop_clk; stop_active |-> !(cpu_clk_en || periph_clk_en || osc_run); endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("Stop clocks wrong.");
  property p_idle_in;
    hit_wr && sfr_wdata == 8'h01 && instr_done && run && !irq_pending |=> idle_active;
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("Idle not entered.");
  property p_stop_in; hit_wr && sfr_wdata[1] && instr_done && run |=> stop_active; endproperty
  a_stop_in: assert property (p_stop_in) else $error("Stop not entered.");
  // Quiet idle must persist; any wake or reset source releases this check.
  property p_idle_hold;
    idle_active && !irq_pending && !watchdog_reset && ext_reset_pin_n && !reset_request
      |=> idle_active;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Idle left early.");
  property p_wdt; idle_active && watchdog_reset |=> reset_request; endproperty
  a_wdt: assert property (p_wdt) else $error("Watchdog ignored in idle.");
  property p_cld; stop_wait <= CLD_MAX; endproperty
  a_cld: assert property (p_cld) else $error("Detector did not fire.");
  c_idle: cover property (idle_active ##1 !idle_active);
  c_stop: cover property ($rose(stop_active));
  c_req: cover property ($rose(reset_request));
endmodule : pmc_power_ctrl_chk
bind pmc_power_ctrl pmc_power_ctrl_chk #(.CLD_CYCLES(CLD_CYCLES)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .instr_done(instr_done), .irq_pending(irq_pending),
  .watchdog_reset(watchdog_reset), .ext_reset_pin_n(ext_reset_pin_n),
  .clock_loss_detector_en(clock_loss_detector_en), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .osc_run(osc_run), .idle_active(idle_active),
  .stop_active(stop_active), .reset_request(reset_request));
`default_nettype wire

// [pmc_power_ctrl_test.sv]
// Self-checking testbench for the CPU power mode control.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_power_ctrl_test;
  import pmc_pkg::*;
  // Short detector count keeps the stop runs brief.
  localparam int CLD = 20;
  localparam logic [7:0] PC = `PMC_POWER_CONTROL_ADDR;
  logic mclk, reset_n, sfr_wr, sfr_rd, instr_done, next_instr_one_byte, irq_pending;
  logic watchdog_reset, ext_reset_pin_n, clock_loss_detector_en;
  logic cpu_clk_en, periph_clk_en, osc_run, idle_active, stop_active, reset_request;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] restart_vector;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  pmc_power_ctrl #(.CLD_CYCLES(CLD)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .instr_done(instr_done), .next_instr_one_byte(next_instr_one_byte),
    .irq_pending(irq_pending), .watchdog_reset(watchdog_reset),
    .ext_reset_pin_n(ext_reset_pin_n), .clock_loss_detector_en(clock_loss_detector_en),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
    .idle_active(idle_active), .stop_active(stop_active),
    .reset_request(reset_request), .restart_vector(restart_vector));
  //////////////////////////////////////////////////////////////////////////////
  // Compare a value, counting every comparison.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Status word: idle, stop, cpu clock, peripheral clock, oscillator, reset request.
  task automatic st(input logic [5:0] exp);
    chk({idle_active, stop_active, cpu_clk_en, periph_clk_en, osc_run, reset_request}, exp);
  endtask : st
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic fin);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    instr_done = fin;
    @(negedge mclk);
    sfr_wr = 1'h0;
    instr_done = 1'h0;
  endtask : wr
  // Read data stands for one cycle only, so it is taken at the next falling edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(negedge mclk);
    sfr_rd = 1'h0;
    chk(sfr_rdata, exp);
  endtask : rd
  task automatic do_reset(input int n);
    reset_n = 1'h0;
    {sfr_wr, sfr_rd, instr_done, next_instr_one_byte} = 4'h0;
    {irq_pending, watchdog_reset, clock_loss_detector_en} = 3'h0;
    ext_reset_pin_n = 1'h1;
    {sfr_addr, sfr_wdata} = 16'h0000;
    cyc(n);
    reset_n = 1'h1;
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    st(6'h0E);
    rd(PC, 8'h00);
    wr(PC, 8'hFC, 1'h0);
    rd(PC, 8'hFC);
    wr(8'h86, 8'h00, 1'h0);
    rd(8'h86, 8'h00);
    rd(PC, 8'hFC);
  endtask : t_regs
  // Idle entry waits for the end of the writing instruction.
  task automatic t_idle;
    wr(PC, 8'hA5, 1'h0);
    rd(PC, 8'hA4);
    st(6'h0E);
    instr_done = 1'h1;
    cyc(1);
    instr_done = 1'h0;
    st(6'h26);
    // The watchdog stays quiet here, as if software had disabled it before idle.
    cyc(6);
    st(6'h26);
    rd(PC, 8'hA4);
    irq_pending = 1'h1;
    cyc(1);
    st(6'h0E);
    irq_pending = 1'h0;
    rd(PC, 8'hA4);
  endtask : t_idle
  // An interrupt during the idle write blocks later wakes only with a one-byte follower.
  task automatic t_follow(input logic one);
    st(6'h0E);
    irq_pending = 1'h1;
    next_instr_one_byte = one;
    wr(PC, 8'h01, 1'h1);
    irq_pending = 1'h0;
    next_instr_one_byte = 1'h0;
    st(6'h26);
    cyc(2);
    irq_pending = 1'h1;
    cyc(1);
    st(one ? 6'h26 : 6'h0E);
    irq_pending = 1'h0;
    watchdog_reset = 1'h1;
    cyc(1);
    chk(reset_request, 1'h1);
    chk(restart_vector, `PMC_RESET_VECTOR);
    do_reset(2);
  endtask : t_follow
  // Stop ignores interrupts and the watchdog; only the detector or the pin ends it.
  task automatic t_stop(input logic en);
    int n;
    n = 0;
    st(6'h0E);
    clock_loss_detector_en = en;
    // Without the detector the write does not end its instruction, so stop must wait for the pulse.
    wr(PC, 8'h03, en);
    if (!en) begin
      cyc(1);
      st(6'h0E);
      instr_done = 1'h1;
      cyc(1);
      instr_done = 1'h0;
    end
    st(6'h10);
    irq_pending = 1'h1;
    watchdog_reset = 1'h1;
    while (!reset_request && n < 60) begin
      cyc(1);
      n++;
    end
    chk(reset_request, en);
    if (en) chk(n >= CLD && n <= CLD + 3, 1'h1);
    st(en ? 6'h11 : 6'h10);
    if (!en) begin
      ext_reset_pin_n = 1'h0;
      cyc(3);
      chk(reset_request, 1'h1);
    end
    do_reset(2);
  endtask : t_stop
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    do_reset(12);
    t_regs;
    t_idle;
    t_follow(1'h0);
    t_follow(1'h1);
    t_stop(1'h1);
    t_stop(1'h0);
    complete_run;
  end
endmodule : pmc_power_ctrl_test
`default_nettype wire
